// *** test/board_reset_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
module board_reset_gen
  import proc_reset_pkg::*;
#(
  parameter int unsigned MIN1 = MIN_RESET_CYCLES_DIV1
) (
  input  wire logic mclk_in,
  input  wire logic go_in,
  input  wire logic ratio_in,
  input  wire logic cut_in,
  output wire logic ext_reset_n_out,
  output wire logic busy_out
);
  int unsigned cnt_q = 0;
  // low time per ratio; cut_in breaks it on purpose
  always @(posedge mclk_in) begin
    if (go_in && !busy_out) begin
      cnt_q <= cut_in ? 5 : ((ratio_in == RATIO_DIV1) ? MIN1 : MIN_RESET_CYCLES_DIV2);
    end else if (cnt_q != 0) begin
      cnt_q <= cnt_q - 1;
    end
  end
  assign busy_out        = (cnt_q != 0);
  assign ext_reset_n_out = !busy_out;
endmodule
`default_nettype wire

// *** test/processor_reset_control_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module processor_reset_control_checker
  import proc_reset_pkg::*;
(
  input  wire logic mclk_in,
  input  wire logic reset_in,
  input  wire logic ext_reset_n_in,
  input  wire logic clock_ratio_select_in,
  input  wire logic hold_request_in,
  input  wire logic core_clock_enable_out,
  input  wire logic core_reset_out,
  input  wire logic pins_in_reset_out,
  input  wire logic init_active_out,
  input  wire logic bus_release_acknowledge_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  logic ratio_q;
  // Ratio seen while in reset; assumes pin steady near release
  always_ff @(posedge mclk_in) begin
    if (core_reset_out) begin
      ratio_q <= clock_ratio_select_in;
    end
  end
  sequence rel_s;
    $rose(ext_reset_n_in) ##1 ext_reset_n_in [*3];
  endsequence
  sequence held_s;
    hold_request_in [*4];
  endsequence
  AST_PINS_EQ: assert property (pins_in_reset_out == core_reset_out)
    else $error("pins and core reset differ");
  AST_RESET_ENTRY: assert property (!ext_reset_n_in [*4] |-> pins_in_reset_out)
    else $error("pins not in reset");
  AST_REL_SYNC: assert property ($rose(ext_reset_n_in) && core_reset_out |-> core_reset_out [*2])
    else $error("release not synchronised");
  AST_REL_INIT: assert property (rel_s |-> !core_reset_out && init_active_out)
    else $error("no initialization after release");
  AST_DIV1: assert property (!core_reset_out && ratio_q == RATIO_DIV1 |-> core_clock_enable_out)
    else $error("divide by one enable low");
  AST_DIV2: assert property (!core_reset_out && ratio_q == RATIO_DIV2 |->
    core_clock_enable_out != $past(core_clock_enable_out))
    else $error("divide by two enable not alternating");
  AST_HOLD_IN_RESET: assert property ((hold_request_in && core_reset_out) [*5] |->
    bus_release_acknowledge_out)
    else $error("hold not granted in reset");
  AST_HOLD_KEPT: assert property (held_s ##0 bus_release_acknowledge_out |=> bus_release_acknowledge_out)
    else $error("hold acknowledge lost");
endmodule
bind processor_reset_control processor_reset_control_checker u_chk (.mclk_in(mclk_in), .reset_in(reset_in),
  .ext_reset_n_in(ext_reset_n_in), .clock_ratio_select_in(clock_ratio_select_in), .hold_request_in(hold_request_in),
  .core_clock_enable_out(core_clock_enable_out), .core_reset_out(core_reset_out),
  .pins_in_reset_out(pins_in_reset_out), .init_active_out(init_active_out),
  .bus_release_acknowledge_out(bus_release_acknowledge_out));
`default_nettype wire

// *** test/test_processor_reset_control.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_processor_reset_control
  import proc_reset_pkg::*;
;
  logic mclk_in = 1'h0;
  logic reset_in = 1'h1;
  logic ratio = RATIO_DIV2;
  logic hold = 1'h0;
  logic idle = 1'h0;
  logic go = 1'h0;
  logic cut = 1'h0;
  wire logic ext_n, busy, cke, crst, pins, istart, iact, ack, tshort;
  int failures = 0;
  int checked = 0;
  always #5 mclk_in = ~mclk_in;
  board_reset_gen #(.MIN1(100)) gen (.mclk_in(mclk_in), .go_in(go), .ratio_in(ratio), .cut_in(cut),
    .ext_reset_n_out(ext_n), .busy_out(busy));
  processor_reset_control #(.MIN_DIV1_CYCLES(100)) DUT (.mclk_in(mclk_in), .reset_in(reset_in),
    .ext_reset_n_in(ext_n), .clock_ratio_select_in(ratio), .hold_request_in(hold), .bus_idle_in(idle),
    .core_clock_enable_out(cke), .core_reset_out(crst), .pins_in_reset_out(pins), .init_start_out(istart),
    .init_active_out(iact), .bus_release_acknowledge_out(ack), .reset_too_short_out(tshort));
  task automatic end_of_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic step(int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic chk(logic e, logic g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic wait_free();
    for (int i = 0; i < 200 && busy; i++) step(1);
    if (busy) begin
      failures++;
      end_of_test();
    end
  endtask
  task automatic t_release(logic r, logic c);
    logic e;
    logic ok;
    int n;
    ratio = r;
    cut = c;
    go = 1'h1;
    step(1);
    go = 1'h0;
    wait_free();
    chk(1'h1, pins);
    for (int i = 0; i < 8 && istart !== 1'h1; i++) step(1);
    chk(1'h1, istart);
    if (istart !== 1'h1) end_of_test();
    chk(c, tshort);
    step(1);
    chk(1'h0, istart);
    chk(1'h1, iact);
    e = cke;
    step(1);
    chk((r == RATIO_DIV1) ? 1'h1 : ~e, cke);
    // Initialization lasts its enable count plus the one SEQ_RESET cycle
    n = 3;
    for (int i = 0; i < 80 && iact === 1'h1; i++) begin
      step(1);
      if (iact === 1'h1) n++;
    end
    chk(1'h0, iact);
    if (iact !== 1'h0) end_of_test();
    if (r == RATIO_DIV1) begin
      ok = (n == INIT_CYCLES + 1);
    end else begin
      ok = (n >= 2 * INIT_CYCLES) && (n <= 2 * INIT_CYCLES + 1);
    end
    chk(1'h1, ok);
    $display("release test done");
  endtask
  task automatic t_hold();
    cut = 1'h0;
    go = 1'h1;
    step(1);
    go = 1'h0;
    hold = 1'h1;
    step(6);
    chk(1'h1, ack);
    wait_free();
    step(8);
    chk(1'h1, ack);
    hold = 1'h0;
    step(4);
    chk(1'h0, ack);
    hold = 1'h1;
    step(5);
    chk(1'h0, ack);
    idle = 1'h1;
    step(3);
    chk(1'h1, ack);
    idle = 1'h0;
    go = 1'h1;
    step(1);
    go = 1'h0;
    step(10);
    chk(1'h1, crst);
    chk(1'h1, ack);
    hold = 1'h0;
    step(5);
    chk(1'h0, ack);
    wait_free();
    $display("hold test done");
  endtask
  initial begin
    step(2);
    reset_in = 1'h0;
    step(3);
    t_release(RATIO_DIV2, 1'h0);
    t_release(RATIO_DIV1, 1'h0);
    t_release(RATIO_DIV1, 1'h1);
    t_release(RATIO_DIV2, 1'h1);
    t_hold();
    end_of_test();
  end
endmodule
`default_nettype wire

// *** verilog/proc_reset_pkg.sv ***
package proc_reset_pkg;

  // ----------------------------------------------------------------
  // Reset hold minimums, in reference clock cycles
  // ----------------------------------------------------------------
  localparam int unsigned MIN_RESET_CYCLES_DIV2 = 32;
  localparam int unsigned MIN_RESET_CYCLES_DIV1 = 10000;
  localparam int unsigned RESET_CNT_W           = 14;

  // ----------------------------------------------------------------
  // Initialization sequence length, in core clock enables
  // ----------------------------------------------------------------
  localparam int unsigned INIT_CYCLES = 16;
  localparam int unsigned INIT_CNT_W  = 8;

  // ----------------------------------------------------------------
  // Levels and reset values
  // ----------------------------------------------------------------
  localparam logic RATIO_DIV1       = 1'h1;
  localparam logic RATIO_DIV2       = 1'h0;
  localparam logic EXT_RESET_ACTIVE = 1'h0;
  localparam logic SYNC_RESET_VALUE = 1'h0;

  typedef enum logic [1:0] {
    SEQ_RESET,
    SEQ_INIT,
    SEQ_RUN
  } seq_state_t;

  typedef enum logic {
    HOLD_IDLE,
    HOLD_GRANTED
  } hold_state_t;

endpackage

// *** verilog/processor_reset_control.sv ***
`timescale 1ns/1ps
`default_nettype none

module processor_reset_control
  import proc_reset_pkg::*;
#(
  parameter int unsigned MIN_DIV1_CYCLES = MIN_RESET_CYCLES_DIV1,
  parameter int unsigned MIN_DIV2_CYCLES = MIN_RESET_CYCLES_DIV2,
  parameter int unsigned INIT_LEN        = INIT_CYCLES
) (
  input  wire logic mclk_in,
  input  wire logic reset_in,
  input  wire logic ext_reset_n_in,
  input  wire logic clock_ratio_select_in,
  input  wire logic hold_request_in,
  input  wire logic bus_idle_in,
  output var  logic core_clock_enable_out,
  output var  logic core_reset_out,
  output var  logic pins_in_reset_out,
  output var  logic init_start_out,
  output var  logic init_active_out,
  output var  logic bus_release_acknowledge_out,
  output var  logic reset_too_short_out
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_sync_q;
  logic ratio_meta_q;
  logic ratio_sync_q;
  logic hold_meta_q;
  logic hold_sync_q;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rst_meta_q <= EXT_RESET_ACTIVE;
      rst_sync_q <= EXT_RESET_ACTIVE;
    end else begin
      rst_meta_q <= ext_reset_n_in;
      rst_sync_q <= rst_meta_q;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      ratio_meta_q <= SYNC_RESET_VALUE;
      ratio_sync_q <= SYNC_RESET_VALUE;
      hold_meta_q  <= SYNC_RESET_VALUE;
      hold_sync_q  <= SYNC_RESET_VALUE;
    end else begin
      ratio_meta_q <= clock_ratio_select_in;
      ratio_sync_q <= ratio_meta_q;
      hold_meta_q  <= hold_request_in;
      hold_sync_q  <= hold_meta_q;
    end
  end

  logic ext_reset_active;
  assign ext_reset_active = (rst_sync_q == EXT_RESET_ACTIVE);

  // ----------------------------------------------------------------
  // Clock ratio capture
  // ----------------------------------------------------------------
  // Ratio is only taken while reset is held; a change while running
  // would tear the core clock, so it is ignored until the next reset.
  logic ratio_q;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      ratio_q <= RATIO_DIV2;
    end else if (ext_reset_active) begin
      ratio_q <= ratio_sync_q;
    end
  end

  // ----------------------------------------------------------------
  // Core clock enable divider
  // ----------------------------------------------------------------
  logic div_phase_q;
  logic core_en_d;

  always_comb begin
    core_en_d = (ratio_q == RATIO_DIV1) ? 1'h1 : div_phase_q;
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      div_phase_q           <= 1'h0;
      core_clock_enable_out <= 1'h0;
    end else begin
      div_phase_q           <= ~div_phase_q;
      core_clock_enable_out <= core_en_d;
    end
  end

  // ----------------------------------------------------------------
  // Reset hold length monitor
  // ----------------------------------------------------------------
  logic [RESET_CNT_W-1:0] hold_cnt_q;
  logic [RESET_CNT_W-1:0] min_cycles;

  assign min_cycles = (ratio_q == RATIO_DIV1) ? RESET_CNT_W'(MIN_DIV1_CYCLES)
                                              : RESET_CNT_W'(MIN_DIV2_CYCLES);

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      hold_cnt_q <= '0;
    end else if (!ext_reset_active) begin
      hold_cnt_q <= '0;
    end else if (hold_cnt_q != '1) begin
      hold_cnt_q <= hold_cnt_q + RESET_CNT_W'(1);
    end
  end

  logic release_edge;
  assign release_edge = !ext_reset_active && core_reset_out;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      reset_too_short_out <= 1'h0;
    end else if (release_edge) begin
      reset_too_short_out <= (hold_cnt_q < min_cycles);
    end else if (ext_reset_active) begin
      reset_too_short_out <= 1'h0;
    end
  end

  // ----------------------------------------------------------------
  // Reset and initialization sequencer
  // ----------------------------------------------------------------
  seq_state_t             seq_q;
  logic [INIT_CNT_W-1:0]  init_cnt_q;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      seq_q      <= SEQ_RESET;
      init_cnt_q <= '0;
    end else if (ext_reset_active) begin
      seq_q      <= SEQ_RESET;
      init_cnt_q <= '0;
    end else begin
      unique case (seq_q)
        SEQ_RESET: begin
          seq_q      <= SEQ_INIT;
          init_cnt_q <= '0;
        end
        SEQ_INIT: begin
          if (core_en_d) begin
            if (init_cnt_q == INIT_CNT_W'(INIT_LEN - 1)) begin
              seq_q <= SEQ_RUN;
            end
            init_cnt_q <= init_cnt_q + INIT_CNT_W'(1);
          end
        end
        SEQ_RUN: begin
          seq_q <= SEQ_RUN;
        end
        // Unused fourth code falls back to reset
        default: begin
          seq_q      <= SEQ_RESET;
          init_cnt_q <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      core_reset_out    <= 1'h1;
      pins_in_reset_out <= 1'h1;
      init_start_out    <= 1'h0;
      init_active_out   <= 1'h0;
    end else begin
      core_reset_out    <= ext_reset_active;
      pins_in_reset_out <= ext_reset_active;
      init_start_out    <= !ext_reset_active && (seq_q == SEQ_RESET);
      init_active_out   <= !ext_reset_active && (seq_q != SEQ_RUN);
    end
  end

  // ----------------------------------------------------------------
  // Bus hold arbitration
  // ----------------------------------------------------------------
  // Deliberately not reset by the external reset pin, only by the
  // block's own reset, so arbitration survives a processor reset.
  hold_state_t hold_q;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      hold_q <= HOLD_IDLE;
    end else begin
      unique case (hold_q)
        HOLD_IDLE: begin
          if (hold_sync_q && (bus_idle_in || ext_reset_active)) begin
            hold_q <= HOLD_GRANTED;
          end
        end
        HOLD_GRANTED: begin
          if (!hold_sync_q) begin
            hold_q <= HOLD_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      bus_release_acknowledge_out <= 1'h0;
    end else begin
      bus_release_acknowledge_out <= (hold_q == HOLD_GRANTED);
    end
  end

endmodule

`default_nettype wire
